/* hdl/lcd_dither_and_frame_addressing.sv */
`timescale 1ns/1ps
module lcd_dither_and_frame_addressing
    import lcd_dither_pkg::*;
(
    input  wire logic        clk_i,          // System clock, 40 MHz.
    input  wire logic        sys_rst_i,      // Synchronous reset, active high.
    input  wire logic [31:0] reg_addr_i,     // Register byte address.
    input  wire logic [31:0] reg_wdata_i,    // Register write data.
    input  wire logic        reg_wr_i,       // Write strobe.
    input  wire logic        reg_rd_i,       // Read strobe.
    input  wire logic [3:0]  pixel_gray_i,   // Gray level of the current pixel.
    output logic      [31:0] reg_rdata_o,    // Read data, one cycle after strobe.
    output logic             pixel_clock_o,  // Panel pixel clock.
    output logic      [3:0]  panel_data_o,   // Panel data bus.
    output logic             line_end_o,     // Pulse at the end of each line.
    output logic             frame_end_o,    // Pulse at the end of each frame.
    output logic [ADDR_W-1:0] fetch_addr_o   // Current frame-buffer fetch address.
);

    //--------------------------------------------------------------------------
    // Helper functions
    //--------------------------------------------------------------------------
    // Clamp the divider so the pixel clock stays at or below its ceiling.
    function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
        if (d < DIV_W'(PIX_MIN_HALF_CYC)) begin
            clamp_div = DIV_W'(PIX_MIN_HALF_CYC);
        end else begin
            clamp_div = d;
        end
    endfunction : clamp_div

    // Temporal modulation: below level 14 the pixel is on when the accumulated level overflows.
    function automatic logic gray_on(input logic [GRAY_W-1:0] lvl,
                                     input logic [FRAME_W-1:0] frm,
                                     input logic [DUTY67_W-1:0] pat);
        logic [GRAY_W:0] acc;
        acc = {1'b0, lvl} * 5'(frm) + 5'(lvl);
        if (lvl == 4'hF) begin
            gray_on = 1'b1;
        end else if (lvl == 4'hE) begin
            gray_on = pat[5'(frm) % 5'd28];
        end else begin
            gray_on = (acc[GRAY_W-1:0] < lvl);
        end
    endfunction : gray_on

    //--------------------------------------------------------------------------
    // Register state
    //--------------------------------------------------------------------------
    logic                   enable_q;
    logic                   gray_mode_q;
    logic [DIV_W-1:0]       div_q;
    logic [ADDR_W-1:0]      upper_base_q;
    logic [ADDR_W-1:0]      lower_base_q;
    logic [PAGE_W-1:0]      page_q;
    logic [SKIP_W-1:0]      skip_q;
    logic [LINE_W-1:0]      line_count_q;
    logic [DUTY67_W-1:0]    duty67_q;
    logic [DITH_MODE_W-1:0] dith_mode_q;
    logic [31:0]            rdata_d;
    logic                   half_tick;
    logic [DIV_W-1:0]       div_cnt_q;
    logic [PAGE_W-1:0]      col_q;
    logic [LINE_W-1:0]      row_q;
    logic [FRAME_W-1:0]     frame_q;
    logic [ADDR_W-1:0]      line_addr_q;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SCAN = 2'b10
    } scan_state_t;
    scan_state_t state_q;

    //--------------------------------------------------------------------------
    // Register writes
    //--------------------------------------------------------------------------
    // Control, base and geometry registers follow each write strobe.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            enable_q     <= 1'b0;
            gray_mode_q  <= 1'b0;
            div_q        <= DIV_MIN;
            upper_base_q <= '0;
            lower_base_q <= '0;
            page_q       <= '0;
            skip_q       <= '0;
            line_count_q <= '0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_CTRL: begin
                    enable_q    <= reg_wdata_i[CTRL_ENABLE_BIT];
                    gray_mode_q <= reg_wdata_i[CTRL_GRAY_BIT];
                    div_q       <= reg_wdata_i[CTRL_DIV_LSB +: DIV_W];
                end
                ADDR_UPPER_BASE: upper_base_q <= {reg_wdata_i[ADDR_W-1:4], ~BURST_ALIGN_MASK & 4'h0};
                ADDR_LOWER_BASE: lower_base_q <= reg_wdata_i[ADDR_W-1:0];
                ADDR_GEOMETRY: begin
                    page_q       <= reg_wdata_i[PAGE_W-1:0];
                    skip_q       <= reg_wdata_i[GEO_SKIP_LSB +: SKIP_W];
                    line_count_q <= reg_wdata_i[22 +: LINE_W];
                end
                default: begin
                end
            endcase
        end
    end

    // Dither registers live apart so their reset values stay in one place.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            duty67_q    <= DUTY67_RESET;
            dith_mode_q <= DITH_MODE_RESET;
        end else if (reg_wr_i && reg_addr_i == ADDR_DUTY67) begin
            duty67_q <= reg_wdata_i[DUTY67_W-1:0];
        end else if (reg_wr_i && reg_addr_i == ADDR_DITH_MODE) begin
            dith_mode_q <= reg_wdata_i[DITH_MODE_W-1:0];
        end
    end

    //--------------------------------------------------------------------------
    // Register reads
    //--------------------------------------------------------------------------
    // Unmapped addresses read as zero; reads have no side effects.
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (reg_addr_i)
            ADDR_CTRL:       rdata_d = {14'h0000, div_q, 6'h00, gray_mode_q, enable_q};
            ADDR_UPPER_BASE: rdata_d = {4'h0, upper_base_q};
            ADDR_LOWER_BASE: rdata_d = {4'h0, lower_base_q};
            ADDR_GEOMETRY:   rdata_d = {line_count_q, skip_q, page_q};
            ADDR_STATUS:     rdata_d = {8'h00, frame_q, row_q, 8'h00, state_q};
            ADDR_FETCH:      rdata_d = {4'h0, fetch_addr_o};
            ADDR_DUTY67:     rdata_d = {4'h0, duty67_q};
            ADDR_DITH_MODE:  rdata_d = {13'h0000, dith_mode_q};
            default:         rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    //--------------------------------------------------------------------------
    // Pixel clock divider
    //--------------------------------------------------------------------------
    // Half-period enable; a short divider is clamped rather than trusted.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !enable_q) begin
            div_cnt_q <= '0;
        end else if (half_tick) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end
    assign half_tick = enable_q && (div_cnt_q >= clamp_div(div_q) - 1'b1);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !enable_q) begin
            pixel_clock_o <= 1'b0;
        end else if (half_tick) begin
            pixel_clock_o <= ~pixel_clock_o;
        end
    end

    //--------------------------------------------------------------------------
    // Scan sequencing and fetch addressing
    //--------------------------------------------------------------------------
    // Counters advance on the falling half of the pixel clock.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q     <= ST_IDLE;
            col_q       <= '0;
            row_q       <= '0;
            frame_q     <= '0;
            line_addr_q <= '0;
            line_end_o  <= 1'b0;
            frame_end_o <= 1'b0;
        end else begin
            line_end_o  <= 1'b0;
            frame_end_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    col_q       <= '0;
                    row_q       <= '0;
                    line_addr_q <= upper_base_q;
                    if (enable_q) begin
                        state_q <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (!enable_q) begin
                        state_q <= ST_IDLE;
                    end else if (half_tick && pixel_clock_o) begin
                        if (col_q >= page_q) begin
                            col_q      <= '0;
                            line_end_o <= 1'b1;
                            if (row_q >= line_count_q) begin
                                row_q       <= '0;
                                frame_q     <= frame_q + 1'b1;
                                frame_end_o <= 1'b1;
                                line_addr_q <= upper_base_q;
                            end else begin
                                row_q       <= row_q + 1'b1;
                                line_addr_q <= line_addr_q + ADDR_W'(page_q) + ADDR_W'(skip_q);
                            end
                        end else begin
                            col_q <= col_q + 1'b1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fetch_addr_o <= '0;
        end else begin
            fetch_addr_o <= line_addr_q + ADDR_W'(col_q);
        end
    end

    //--------------------------------------------------------------------------
    // Gray generation
    //--------------------------------------------------------------------------
    // frame-based gray modulation
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            panel_data_o <= 4'h0;
        end else if (state_q != ST_SCAN) begin
            panel_data_o <= 4'h0;
        end else if (gray_mode_q) begin
            panel_data_o <= {4{gray_on(pixel_gray_i, frame_q, duty67_q)}};
        end else begin
            panel_data_o <= pixel_gray_i;
        end
    end

endmodule : lcd_dither_and_frame_addressing

/* hdl/lcd_dither_pkg.sv */
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
package lcd_dither_pkg;

    //--------------------------------------------------------------------------
    // Register offsets
    //--------------------------------------------------------------------------
    localparam logic [31:0] ADDR_CTRL       = 32'h01F0_0000;
    localparam logic [31:0] ADDR_UPPER_BASE = 32'h01F0_0004;
    localparam logic [31:0] ADDR_LOWER_BASE = 32'h01F0_0008;
    localparam logic [31:0] ADDR_GEOMETRY   = 32'h01F0_000C;
    localparam logic [31:0] ADDR_STATUS     = 32'h01F0_0010;
    localparam logic [31:0] ADDR_FETCH      = 32'h01F0_0014;
    localparam logic [31:0] ADDR_DUTY67     = 32'h01F0_003C;
    localparam logic [31:0] ADDR_DITH_MODE  = 32'h01F0_0044;

    //--------------------------------------------------------------------------
    // Field positions and widths
    //--------------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_GRAY_BIT   = 1;
    localparam int CTRL_DIV_LSB    = 8;
    localparam int DIV_W           = 10;
    localparam int PAGE_W          = 11;
    localparam int SKIP_W          = 11;
    localparam int LINE_W          = 10;
    localparam int GEO_SKIP_LSB    = 11;
    localparam int ADDR_W          = 28;
    localparam int DUTY67_W        = 28;
    localparam int DITH_MODE_W     = 19;
    localparam int GRAY_W          = 4;
    localparam int FRAME_W         = 4;

    //--------------------------------------------------------------------------
    // Reset values and timing
    //--------------------------------------------------------------------------
    localparam logic [DUTY67_W-1:0]    DUTY67_RESET    = 28'h7FDFBFE;
    localparam logic [DITH_MODE_W-1:0] DITH_MODE_RESET = 19'h00000;
    localparam logic [3:0]             BURST_ALIGN_MASK = 4'hF;
    localparam logic [DIV_W-1:0]       DIV_MIN          = 10'h001;
    localparam int SYS_CLK_MHZ_X10   = 400;
    localparam int PIX_MAX_MHZ_X10   = 165;
    localparam int SYS_REF_MHZ_X10   = 660;
    // Least system cycles per pixel clock half period, scaled from the 66 MHz case.
    localparam int PIX_MIN_HALF_CYC  =
        (SYS_REF_MHZ_X10 + 2 * PIX_MAX_MHZ_X10 - 1) / (2 * PIX_MAX_MHZ_X10);

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic              pix_clk;
        logic              line_end;
        logic              frame_end;
        logic [3:0]        data;
        logic [ADDR_W-1:0] fetch_addr;
    } panel_out_t;

endpackage : lcd_dither_pkg

/* testbench/lcd_dither_props.sv */
`timescale 1ns/1ps
module lcd_dither_props
    import lcd_dither_pkg::*;
(
    input wire logic        clk_i,          // System clock.
    input wire logic        sys_rst_i,      // Synchronous reset.
    input wire logic [31:0] reg_addr_i,     // Register address.
    input wire logic        reg_rd_i,       // Read strobe.
    input wire logic [31:0] reg_rdata_o,    // Read data.
    input wire logic        pixel_clock_o,  // Panel pixel clock.
    input wire logic        line_end_o,     // Line end pulse.
    input wire logic        frame_end_o     // Frame end pulse.
);
    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    // Every check uses the system clock and sleeps while reset is high.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    rd_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data not zero outside a read slot");
    base_align_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == ADDR_UPPER_BASE |-> reg_rdata_o[3:0] == 4'h0)
        else $error("upper start address low bits not zero");
    pat_width_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == ADDR_DUTY67 |-> reg_rdata_o[31:28] == 4'h0)
        else $error("pattern register wider than 28 bits");
    mode_width_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == ADDR_DITH_MODE |-> reg_rdata_o[31:19] == 13'h0)
        else $error("mode register wider than 19 bits");
    unmapped_zero_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 32'h01F0_0040 |-> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    clk_high_hold_a: assert property ($rose(pixel_clock_o) |=> pixel_clock_o)
        else $error("pixel clock high phase too short");
    clk_low_hold_a: assert property ($fell(pixel_clock_o) |=> !pixel_clock_o)
        else $error("pixel clock low phase too short");
    line_pulse_a: assert property (line_end_o |=> !line_end_o)
        else $error("line end pulse longer than one cycle");
    frame_pulse_a: assert property (frame_end_o |=> !frame_end_o [*3])
        else $error("frame end pulses too close");
endmodule : lcd_dither_props

bind lcd_dither_and_frame_addressing lcd_dither_props chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pixel_clock_o(pixel_clock_o),
    .line_end_o(line_end_o), .frame_end_o(frame_end_o));

/* testbench/panel_model.sv */
`timescale 1ns/1ps
module panel_model (
    input  wire logic        clk_i,      // System clock.
    input  wire logic        rst_i,      // Reset, active high.
    input  wire logic        pix_clk_i,  // Panel pixel clock.
    input  wire logic [3:0]  data_i,     // Panel data bus.
    output logic      [31:0] n_smp_o,    // Pixels latched.
    output logic      [31:0] n_on_o      // Pixels latched fully lit.
);
    logic pix_q;

    //--------------------------------------------------------------------------
    // Pixel latch
    //--------------------------------------------------------------------------
    // The panel shifts data in on the falling pixel clock edge; a pixel only
    // counts as lit when all four lines agree, so split data shows as dark.
    // lit pixel count
    always_ff @(posedge clk_i) begin
        pix_q <= pix_clk_i;
        if (rst_i) begin
            n_smp_o <= 32'h0;
            n_on_o  <= 32'h0;
        end else if (pix_q && !pix_clk_i) begin
            n_smp_o <= n_smp_o + 32'h1;
            n_on_o  <= n_on_o + {31'h0, &data_i};
        end
    end
endmodule : panel_model

/* testbench/test_lcd_dither_and_frame_addressing.sv */
`timescale 1ns/1ps
module test_lcd_dither_and_frame_addressing;
    import lcd_dither_pkg::*;
    logic              clk_i, sys_rst_i, reg_wr_i, reg_rd_i, rd_q, armed;
    logic [31:0]       reg_addr_i, reg_wdata_i, reg_rdata_o, n_smp, n_on, s0, o0, d, e, rnd;
    logic [3:0]        pixel_gray_i, panel_data_o;
    logic              pixel_clock_o, line_end_o, frame_end_o;
    logic [ADDR_W-1:0] fetch_addr_o, min_q;
    logic [31:0]       exp_rd[$];
    logic [ADDR_W-1:0] exp_ln[$];
    int                n_mismatch, n_tests, skip;

    lcd_dither_and_frame_addressing dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .pixel_gray_i(pixel_gray_i),
        .reg_rdata_o(reg_rdata_o), .pixel_clock_o(pixel_clock_o), .panel_data_o(panel_data_o),
        .line_end_o(line_end_o), .frame_end_o(frame_end_o), .fetch_addr_o(fetch_addr_o));
    panel_model pm_u (.clk_i(clk_i), .rst_i(sys_rst_i), .pix_clk_i(pixel_clock_o), .data_i(panel_data_o),
        .n_smp_o(n_smp), .n_on_o(n_on));

    //--------------------------------------------------------------------------
    // Clock and helpers
    //--------------------------------------------------------------------------
    // Free running 40 MHz system clock.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            n_mismatch++;
            $display("Error %0t: got %h want %h", $time, got, want);
        end
    endtask : chk

    task wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= v;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // The expected word is queued before the strobe, so the watcher owns the compare.
    task rd(input logic [31:0] a, input logic [31:0] want);
        exp_rd.push_back(want);
        @(posedge clk_i);
        reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd

    task frames(input int n);
        repeat (n) begin
            @(posedge clk_i);
            while (frame_end_o !== 1'b1) @(posedge clk_i);
        end
    endtask : frames

    task conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    //--------------------------------------------------------------------------
    // Output watcher
    //--------------------------------------------------------------------------
    // Read data is taken in its one valid cycle. Each line's base is the lowest
    // fetch address seen in it; the cycles around a line change are skipped
    // because the registered address may still show the previous line's tail.
    always @(posedge clk_i) begin
        rd_q <= reg_rd_i;
        if (rd_q) chk(reg_rdata_o, exp_rd.pop_front());
        if (line_end_o === 1'b1 && armed) begin
            chk({4'h0, min_q}, {4'h0, exp_ln.pop_front()});
            armed = (exp_ln.size() != 0);
        end
        if (line_end_o === 1'b1 || frame_end_o === 1'b1) begin
            min_q = '1;
            skip = 3;
        end else if (skip > 0) skip--;
        else if (fetch_addr_o < min_q) min_q = fetch_addr_o;
        if (frame_end_o === 1'b1 && exp_ln.size() != 0) armed = 1'b1;
    end

    // Cuts a hang short well above the expected run of about 16600 cycles.
    initial begin
        repeat (80000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end

    //--------------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------------
    initial begin
        sys_rst_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 32'h0; reg_wdata_i = 32'h0;
        pixel_gray_i = 4'h0; rd_q = 1'b0; armed = 1'b0; min_q = '1; skip = 0; n_mismatch = 0; n_tests = 0;
        rnd = $urandom(32'h605a);
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(ADDR_DUTY67, {4'h0, DUTY67_RESET});
        rd(ADDR_DITH_MODE, 32'h0);
        rnd = $urandom();
        wr(ADDR_DUTY67, rnd);
        rd(ADDR_DUTY67, {4'h0, rnd[27:0]});
        wr(ADDR_DUTY67, {4'h0, DUTY67_RESET});
        wr(ADDR_DITH_MODE, 32'h0001_2210);
        rd(ADDR_DITH_MODE, 32'h0001_2210);
        wr(32'h01F0_0040, rnd);
        rd(32'h01F0_0040, 32'h0);
        // A misaligned start must come back with its low nibble cleared.
        wr(ADDR_UPPER_BASE, 32'h0000_0064);
        rd(ADDR_UPPER_BASE, 32'h0000_0060);
        // Width 3, skip 5, two lines: bases step by 8 half-words from 0x60.
        wr(ADDR_GEOMETRY, 32'h0040_2803);
        wr(ADDR_LOWER_BASE, 32'h0000_0070);
        rd(ADDR_LOWER_BASE, 32'h0000_0070);
        exp_ln = '{28'h60, 28'h68, 28'h60, 28'h68};
        pixel_gray_i <= rnd[3:0];
        // Divider 1 is below the clamp, so the pixel clock must run at its limit.
        // pixel clock at clamped rate
        wr(ADDR_CTRL, 32'h0000_0103);
        frames(4);
        for (int lvl = 0; lvl < 16; lvl++) begin
            pixel_gray_i <= lvl[3:0];
            frames(2);
            s0 = n_smp;
            o0 = n_on;
            frames(30);
            d = n_smp - s0;
            e = n_on - o0;
            if (lvl == 0) chk(e, 32'h0);
            else if (lvl == 15) chk(e, d);
            else chk({31'h0, (e != 32'h0) && (e < d)}, 32'h1);
        end
        // Without gray mode the panel data follow the pixel level directly.
        wr(ADDR_CTRL, 32'h0000_0101);
        pixel_gray_i <= rnd[7:4];
        frames(2);
        chk({28'h0, panel_data_o}, {28'h0, rnd[7:4]});
        conclude();
    end
endmodule : test_lcd_dither_and_frame_addressing
